// *** rtl/fbcm_pkg.sv ***
// Package: address map, field positions and types of the frame buffer control map
package fbcm_pkg;
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   localparam int AXI_AW = 21;        // Byte address width
   localparam int SPACE_BIT = 20;     // 1 = control space, 0 = frame buffer
   localparam int FB_LINE_MSB = 18;   // Top byte address bit of 512K space
   localparam int CTRL_HI_LSB = 6;    // Control bits above the 64-byte window
   // ------------------------------------------------------------
   // Register indices (byte address = index * 4)
   // ------------------------------------------------------------
   localparam logic [3:0] REG_LEN_LO = 4'h0;  // 00 line length low
   localparam logic [3:0] REG_STAT = 4'h1;    // 04 refresh/interlace/genlock/setup
   localparam logic [3:0] REG_BASE_MID = 4'h2;  // 08 base 15:8
   localparam logic [3:0] REG_BASE_LO = 4'h3;   // 0C base 7:0
   localparam logic [3:0] REG_HRES_LO = 4'h4;   // 10 horizontal resolution low
   localparam logic [3:0] REG_HMIX = 4'h5;      // 14 hres/htotal high bits
   localparam logic [3:0] REG_HTOT_LO = 4'h6;   // 18 horizontal total low
   localparam logic [3:0] REG_HSYNC = 4'h7;     // 1C hsync width
   localparam logic [3:0] REG_VMIX = 4'h8;      // 20 vres/vtotal high bits
   localparam logic [3:0] REG_VRES_LO = 4'h9;   // 24 vertical resolution low
   localparam logic [3:0] REG_VTOT_LO = 4'hA;   // 28 vertical total low
   localparam logic [3:0] REG_VMISC = 4'hB;     // 2C rank and misc
   localparam logic [3:0] REG_VSYNC = 4'hC;     // 30 vsync width
   localparam logic [3:0] REG_PMIX = 4'hD;      // 34 prescale and misc
   localparam logic [3:0] REG_SYS = 4'hF;       // 3C length/base high, polarity, depth
   localparam logic [7:0] REG_RESET = 8'h00;    // Every register clears on reset
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int STAT_INTL = 4;     // Interlace enable
   localparam int SYS_BASE16 = 2;    // Base bit 16
   localparam int SYS_POL = 3;       // Address sense invert
   localparam int SYS_DEPTH = 4;     // Depth code lsb, 3 bits
   localparam int VMISC_RANK2 = 7;   // Second rank fitted
   localparam int PMIX_PRE = 4;      // Prescale exponent lsb, 3 bits
   localparam logic [2:0] DEPTH_MAX = 3'h4;  // Code 4 = 16 bpp
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {FBCM_IDLE, FBCM_FBRD, FBCM_BRSP, FBCM_RRSP} fbcm_state_t;
endpackage : fbcm_pkg

// *** rtl/fbcm_top.sv ***
// Frame buffer control map: AXI4-Lite slave, VRAM port and chunky video timing
// Functional notes
// RULE1: control space never reaches frame buffer
// RULE2: lowest 64 control bytes hold registers
// RULE3: byte registers on 4-byte stride from 0
// RULE4: exactly sixteen byte-wide configuration registers
// RULE5: wide parameters split; shared registers listed
// RULE6: 32-bit linear 256K or 512K space
// RULE7: pixels from adjacent bits of words
// RULE8: at most two ranks, 512K total
// RULE9: no parity on frame buffer data
// RULE10: depths 1,2,4,8,16 from one clock
// RULE11: pixel clock divided by software prescale
// RULE12: integrator limits pixel data rate
// RULE13: programmable sync, interlaced or not
// RULE14: latch address, size, direction; optional inversion
// RULE15: pixel clock synchronised to bus clock
// RULE16: host bus clock at most 15 MHz; aclk runs at 50 MHz here
// RULE17: line words and resolution set independently
// RULE18: address sense clears low on reset
// RULE19: readback of writes; other lanes ignored
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fbcm_top (
   input wire logic aclk,                                 // Bus clock, 50 MHz
   input wire logic aresetn,                              // Sync reset, low
   input wire logic [fbcm_pkg::AXI_AW-1:0] s_axi_awaddr,  // Write address
   input wire logic [2:0] s_axi_awprot,                   // Unused
   input wire logic s_axi_awvalid,                        // Write address valid
   output logic s_axi_awready,                            // Write address ready
   input wire logic [31:0] s_axi_wdata,                   // Write data
   input wire logic [3:0] s_axi_wstrb,                    // Byte strobes
   input wire logic s_axi_wvalid,                         // Write data valid
   output logic s_axi_wready,                             // Write data ready
   output logic [1:0] s_axi_bresp,                        // Write response
   output logic s_axi_bvalid,                             // Write response valid
   input wire logic s_axi_bready,                         // Write response ready
   input wire logic [fbcm_pkg::AXI_AW-1:0] s_axi_araddr,  // Read address
   input wire logic [2:0] s_axi_arprot,                   // Unused
   input wire logic s_axi_arvalid,                        // Read address valid
   output logic s_axi_arready,                            // Read address ready
   output logic [31:0] s_axi_rdata,                       // Read data
   output logic [1:0] s_axi_rresp,                        // Read response
   output logic s_axi_rvalid,                             // Read data valid
   input wire logic s_axi_rready,                         // Read data ready
   output logic fb_req,                                   // VRAM access pulse
   output logic fb_we,                                    // VRAM write
   output logic fb_rank,                                  // Rank select
   output logic [15:0] fb_addr,                           // Word within rank
   output logic [3:0] fb_be,                              // Byte enables
   output logic [31:0] fb_wdata,                          // Write data
   input wire logic [31:0] fb_rdata,                      // Read data, same cycle as fb_req
   input wire logic pxclk_in,                             // Master pixel clock pin
   output logic [16:0] disp_addr,                         // Display word address
   output logic disp_next,                                // Display word consumed
   input wire logic [31:0] disp_word,                     // Word at disp_addr
   output logic [15:0] pix_value,                         // Pixel colour value
   output logic pix_valid,                                // Pixel strobe
   output logic hsync_out,                                // Horizontal sync
   output logic vsync_out,                                // Vertical sync
   output logic blank_out,                                // Outside active area
   output logic field_out                                 // Odd field when interlaced
);
   import fbcm_pkg::*;
   // ------------------------------------------------------------
   // Register file and decoded parameters
   // ------------------------------------------------------------
   logic [7:0] regs [16];   // Sixteen byte registers
   fbcm_state_t st;         // Bus engine state
   logic pol;               // Address sense invert
   logic two_rank;          // Second rank fitted
   logic [9:0] length;      // Words per line
   logic [16:0] base;       // Display start word
   logic [9:0] hres, htot, vres, vtot;  // Resolutions and totals
   logic [2:0] dcode;       // Clamped depth code
   logic [2:0] pre;         // Prescale exponent
   assign pol = regs[REG_SYS][SYS_POL];
   assign two_rank = regs[REG_VMISC][VMISC_RANK2];
   // Wide parameters are assembled from several byte registers
   assign length = {regs[REG_SYS][1:0], regs[REG_LEN_LO]};  // RULE5
   assign base = {regs[REG_SYS][SYS_BASE16], regs[REG_BASE_MID], regs[REG_BASE_LO]};  // RULE5
   assign hres = {regs[REG_HMIX][1:0], regs[REG_HRES_LO]};  // RULE5
   assign htot = {regs[REG_HMIX][3:2], regs[REG_HTOT_LO]};  // RULE5
   assign vres = {regs[REG_VMIX][1:0], regs[REG_VRES_LO]};  // RULE5
   assign vtot = {regs[REG_VMIX][3:2], regs[REG_VTOT_LO]};  // RULE5
   assign pre = regs[REG_PMIX][PMIX_PRE+:3];
   // Codes above 16 bpp would overrun the word, so they clamp
   assign dcode = (regs[REG_SYS][SYS_DEPTH+:3] > DEPTH_MAX) ? DEPTH_MAX :
                  regs[REG_SYS][SYS_DEPTH+:3];  // RULE10
   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic wr_go, rd_go;            // Requests taken this cycle
   logic aw_ctrl, ar_ctrl;        // Control space selected
   logic aw_in, ar_in;            // Inside the 64-byte window
   logic [16:0] aw_word, ar_word; // Frame buffer word, sense applied
   logic aw_ok, ar_ok;            // Word lies in a fitted rank
   logic [7:0] rd_reg;            // Register addressed by a read
   assign wr_go = (st == FBCM_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign rd_go = (st == FBCM_IDLE) && s_axi_arvalid && !wr_go;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign aw_ctrl = s_axi_awaddr[SPACE_BIT];  // RULE1
   assign ar_ctrl = s_axi_araddr[SPACE_BIT];  // RULE1
   assign aw_in = (s_axi_awaddr[SPACE_BIT-1:CTRL_HI_LSB] == '0);  // RULE2
   assign ar_in = (s_axi_araddr[SPACE_BIT-1:CTRL_HI_LSB] == '0);  // RULE2
   // Inverted sense suits a host whose address lines are active low
   assign aw_word = pol ? ~s_axi_awaddr[FB_LINE_MSB:2] : s_axi_awaddr[FB_LINE_MSB:2];  // RULE14
   assign ar_word = pol ? ~s_axi_araddr[FB_LINE_MSB:2] : s_axi_araddr[FB_LINE_MSB:2];  // RULE14
   assign aw_ok = two_rank || !aw_word[16];  // RULE8
   assign ar_ok = two_rank || !ar_word[16];  // RULE8
   assign rd_reg = regs[s_axi_araddr[5:2]];  // RULE3
   // ------------------------------------------------------------
   // Register writes: lane 0 only, window only
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 16; i++) begin
            regs[i] <= REG_RESET;  // RULE18
         end
      end else if (wr_go && aw_ctrl && aw_in && s_axi_wstrb[0]) begin
         regs[s_axi_awaddr[5:2]] <= s_axi_wdata[7:0];  // RULE4 RULE19
      end
   end
   // ------------------------------------------------------------
   // Bus engine: one transfer at a time, writes before reads
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= FBCM_IDLE;
      end else begin
         case (st)
            FBCM_IDLE: begin
               if (wr_go) begin
                  st <= FBCM_BRSP;
               end else if (rd_go) begin
                  st <= (!ar_ctrl && ar_ok) ? FBCM_FBRD : FBCM_RRSP;
               end
            end
            FBCM_FBRD: st <= FBCM_RRSP;  // VRAM data arrives this cycle
            FBCM_BRSP: if (s_axi_bready) st <= FBCM_IDLE;
            FBCM_RRSP: if (s_axi_rready) st <= FBCM_IDLE;
            default: st <= FBCM_IDLE;
         endcase
      end
   end
   assign s_axi_bvalid = (st == FBCM_BRSP);
   assign s_axi_rvalid = (st == FBCM_RRSP);
   // Responses are latched at the take edge, VRAM read data one edge later, and held until accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= RESP_OKAY;
         s_axi_rresp <= RESP_OKAY;
         s_axi_rdata <= '0;
      end else begin
         if (wr_go) begin
            s_axi_bresp <= (aw_ctrl ? aw_in : aw_ok) ? RESP_OKAY : RESP_SLVERR;  // RULE2
         end
         if (rd_go) begin
            s_axi_rresp <= (ar_ctrl ? ar_in : ar_ok) ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata <= (ar_ctrl && ar_in) ? {24'h000000, rd_reg} : '0;  // RULE19
         end else if (st == FBCM_FBRD) begin
            s_axi_rdata <= fb_rdata;  // RULE6
         end
      end
   end
   // ------------------------------------------------------------
   // VRAM port: address, size and direction latched at take
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_req <= 1'b0;
         fb_we <= 1'b0;
         fb_rank <= 1'b0;
         fb_addr <= '0;
         fb_be <= '0;
         fb_wdata <= '0;
      end else begin
         fb_req <= (wr_go && !aw_ctrl && aw_ok) || (rd_go && !ar_ctrl && ar_ok);  // RULE1
         if (wr_go) begin
            fb_we <= 1'b1;  // RULE14
            {fb_rank, fb_addr} <= aw_word;  // RULE8
            fb_be <= s_axi_wstrb;
            fb_wdata <= s_axi_wdata;  // RULE9
         end else if (rd_go) begin
            fb_we <= 1'b0;  // RULE14
            {fb_rank, fb_addr} <= ar_word;
            fb_be <= 4'hF;
         end
      end
   end
   // ------------------------------------------------------------
   // Pixel clock pin: three flops, change counted when 2 and 3 agree
   // ------------------------------------------------------------
   logic [2:0] px_sync;   // Synchroniser chain
   logic px_lvl;          // Accepted level
   logic px_rise;         // Accepted rising edge
   logic [6:0] pre_cnt;   // Prescale counter
   logic pix_en;          // One pixel per pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         px_sync <= '0;
         px_lvl <= 1'b0;
      end else begin
         px_sync <= {px_sync[1:0], pxclk_in};  // RULE15
         if (px_sync[1] == px_sync[2]) px_lvl <= px_sync[2];
      end
   end
   assign px_rise = (px_sync[1] == px_sync[2]) && px_sync[2] && !px_lvl;
   // Divide accepted edges by 2^pre
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_cnt <= '0;
      end else if (px_rise) begin
         pre_cnt <= pix_en ? '0 : pre_cnt + 7'h01;  // RULE11
      end
   end
   assign pix_en = px_rise && (pre_cnt >= 7'((8'h01 << pre) - 8'h01));  // RULE11
   // ------------------------------------------------------------
   // Sync generator
   // ------------------------------------------------------------
   logic [9:0] hcnt, vcnt;  // Raster position
   logic line_end, frame_end;
   assign line_end = (hcnt >= htot);
   assign frame_end = line_end && (vcnt >= vtot);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hcnt <= '0;
         vcnt <= '0;
         field_out <= 1'b0;
      end else if (pix_en) begin
         hcnt <= line_end ? '0 : hcnt + 10'h001;  // RULE13
         if (line_end) vcnt <= frame_end ? '0 : vcnt + 10'h001;
         if (frame_end) field_out <= regs[REG_STAT][STAT_INTL] && !field_out;  // RULE13
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
         blank_out <= 1'b1;
      end else begin
         hsync_out <= ({2'h0, regs[REG_HSYNC]} > hcnt);  // RULE13
         vsync_out <= ({2'h0, regs[REG_VSYNC]} > vcnt);
         blank_out <= (hcnt >= hres) || (vcnt >= vres);
      end
   end
   // ------------------------------------------------------------
   // Chunky pixel fetch: line stride and resolution are independent
   // ------------------------------------------------------------
   logic [16:0] line_start;  // First word of current line
   logic [9:0] word_ptr;     // Word within line
   logic [4:0] pidx;         // Pixel within word
   logic active, word_done;
   assign active = (hcnt < hres) && (vcnt < vres);
   assign word_done = (pidx == 5'((6'h20 >> dcode) - 6'h01));
   assign disp_addr = line_start + {7'h00, word_ptr};  // RULE17
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_start <= '0;
         word_ptr <= '0;
         pidx <= '0;
      end else if (pix_en) begin
         if (frame_end) begin
            // Odd field starts one stored line further down
            line_start <= base + ((regs[REG_STAT][STAT_INTL] && !field_out) ?
                          {7'h00, length} : 17'h00000);
         end else if (line_end && vcnt < vres) begin
            line_start <= line_start + {7'h00, length};  // RULE17
         end
         if (line_end) begin
            word_ptr <= '0;
            pidx <= '0;
         end else if (active) begin
            pidx <= word_done ? '0 : pidx + 5'h01;
            if (word_done) word_ptr <= word_ptr + 10'h001;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pix_value <= '0;
         pix_valid <= 1'b0;
         disp_next <= 1'b0;
      end else begin
         pix_valid <= pix_en && active;
         disp_next <= pix_en && active && word_done && !line_end;
         if (pix_en && active) begin
            pix_value <= 16'(disp_word >> 5'(pidx << dcode)) &
                         16'((17'h00001 << (5'h01 << dcode)) - 17'h00001);  // RULE7 RULE10
         end
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_fb_read;
      rd_go && !ar_ctrl && ar_ok;
   endsequence
   sequence s_fb_answer;
      fb_req && !fb_we ##1 s_axi_rvalid && (s_axi_rdata == $past(fb_rdata));
   endsequence
   property p_fb_read;
      @(posedge aclk) disable iff (!aresetn) s_fb_read |=> s_fb_answer;
   endproperty
   a_fb_read: assert property (p_fb_read) else $error("frame buffer read lost");  // RULE6
   property p_ctrl_isolated;
      @(posedge aclk) disable iff (!aresetn) (wr_go || rd_go) && (wr_go ? aw_ctrl : ar_ctrl)
         |=> !fb_req;
   endproperty
   a_ctrl_isolated: assert property (p_ctrl_isolated) else $error("control hit VRAM");  // RULE1
   property p_fb_no_regs;
      @(posedge aclk) disable iff (!aresetn) wr_go && !aw_ctrl |=> $stable(regs[REG_SYS]);
   endproperty
   a_fb_no_regs: assert property (p_fb_no_regs) else $error("VRAM write hit regs");  // RULE1
   property p_readback;
      @(posedge aclk) disable iff (!aresetn) rd_go && ar_ctrl && ar_in
         |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(rd_reg)};
   endproperty
   a_readback: assert property (p_readback) else $error("register readback wrong");  // RULE19
   property p_unmapped;
      @(posedge aclk) disable iff (!aresetn) rd_go && ar_ctrl && !ar_in
         |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("outside window not refused");  // RULE2
   property p_rank;
      @(posedge aclk) disable iff (!aresetn) wr_go && !aw_ctrl && !two_rank && aw_word[16]
         |=> !fb_req && s_axi_bresp == RESP_SLVERR;
   endproperty
   a_rank: assert property (p_rank) else $error("absent rank accessed");  // RULE8
   property p_pol_reset;
      @(posedge aclk) !aresetn |=> !pol;
   endproperty
   a_pol_reset: assert property (p_pol_reset) else $error("sense not cleared");  // RULE18
   property p_bresp;
      @(posedge aclk) disable iff (!aresetn) wr_go
         |=> s_axi_bvalid && !s_axi_awready && !s_axi_arready;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response missing");  // RULE19
   property p_chunky;
      @(posedge aclk) disable iff (!aresetn) pix_en && active && dcode == 3'h3 && pidx == 5'h01
         |=> pix_valid && pix_value == {8'h00, $past(disp_word[15:8])};
   endproperty
   a_chunky: assert property (p_chunky) else $error("byte pixel not adjacent bits");  // RULE7
endmodule : fbcm_top

// *** sim/fbcm_bench.sv ***
// Self-checking bench for the frame buffer control map
`timescale 1ns/1ps
module fbcm_bench;
   import fbcm_pkg::*;
   localparam logic [20:0] CTRL = 21'h100000;  // Control space select
   // Video setup as {byte address, value}: 8 bpp raster of 4x2 in an 8x4 total
   localparam logic [15:0] VCFG [10] = '{16'h1004, 16'h1807, 16'h1C02, 16'h2402, 16'h2803,
      16'h3001, 16'h3C30, 16'h0001, 16'h3400, 16'h1400};
   logic aclk = 0, aresetn = 0, pxclk = 0, px_on = 1;
   logic [20:0] s_axi_awaddr = 0, s_axi_araddr = 0, a;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0;
   logic [31:0] s_axi_wdata = 0, seed = 32'h4a556751, d, m;
   logic [3:0] s_axi_wstrb = 0, s;
   logic [1:0] r;
   logic [7:0] regs [16];
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic fb_req, fb_we, fb_rank, pix_valid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata, fb_wdata, fb_rdata, disp_word;
   wire logic [15:0] fb_addr, pix_value;
   wire logic [3:0] fb_be;
   wire logic [16:0] disp_addr;
   wire logic disp_next, hsync_out, vsync_out, blank_out, field_out;
   // Video outputs packed for one compare per pixel
   wire logic [20:0] vid = {disp_next, blank_out, hsync_out, vsync_out, field_out, pix_value};
   int n_mismatch = 0, n_compared = 0, i, n;
   always #10 aclk = ~aclk;
   always #33 pxclk = px_on && !pxclk;  // Unrelated phase, held low while stopped
   fbcm_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fb_req, .fb_we,
      .fb_rank, .fb_addr, .fb_be, .fb_wdata, .fb_rdata, .pxclk_in(pxclk), .disp_addr,
      .disp_next, .disp_word, .pix_value, .pix_valid, .hsync_out, .vsync_out,
      .blank_out, .field_out);
   fbcm_vram u_vram (.aclk, .fb_req, .fb_we, .fb_rank, .fb_addr, .fb_be, .fb_wdata, .fb_rdata,
      .disp_addr, .disp_word);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [20:0] ad, input logic [31:0] dt, input logic [3:0] st);
      int n;
      n = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready}
         <= {ad, dt, st, 3'b111};
      do begin @(posedge aclk); n++; end
      while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && n < 200);
      {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 200);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 200) begin n_mismatch++; conclude(); end
   endtask : wr
   task automatic rd(input logic [20:0] ad);
      int n;
      n = 0;
      @(posedge aclk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'b11};
      do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 200);
      s_axi_arvalid <= 1'b0;
      do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 200);
      {r, d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
      if (n >= 200) begin n_mismatch++; conclude(); end
   endtask : rd
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // All registers, address sense included, come up clear
      for (i = 0; i < 16; i++) begin rd(CTRL | 21'(i * 4)); chk(d, 0); end
      // Random bytes on every stride slot, the spare one included
      for (i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         regs[i] = seed[7:0];
         wr(CTRL | 21'(i * 4), seed, 4'hF);
      end
      wr(CTRL | 21'h04, 32'hFF, 4'hE); chk(r, RESP_OKAY);
      wr(CTRL | 21'h40, 32'h5A, 4'hF); chk(r, RESP_SLVERR);
      rd(CTRL | 21'h40); chk({r, d}, {RESP_SLVERR, 32'h0});
      for (i = 0; i < 16; i++) begin
         rd(CTRL | 21'(i * 4));
         chk(d, {24'h0, regs[i]});
      end
      // Frame buffer words with both ranks, full then partial writes
      wr(CTRL | 21'h2C, 32'h80, 4'hF);
      wr(CTRL | 21'h3C, 32'h00, 4'hF);
      for (i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         a = {2'b00, seed[18:2], 2'b00};
         m = lfsr(seed);
         wr(a, m, 4'hF);
         seed = lfsr(m);
         s = seed[3:0];
         wr(a, seed, s);
         for (int b = 0; b < 4; b++) if (s[b]) m[b*8 +: 8] = seed[b*8 +: 8];
         rd(a); chk({r, d}, {RESP_OKAY, m});
      end
      rd(CTRL); chk(d, {24'h0, regs[0]});
      // Inverted address sense still reads back what it wrote
      wr(CTRL | 21'h3C, 32'h08, 4'hF);
      a = 21'h012344;
      wr(a, 32'hC0FFEE11, 4'hF);
      rd(a); chk(d, 32'hC0FFEE11);
      // The RAM write lands at the response edge, so it is looked at only after the read
      chk(u_vram.mem[~a[18:2]], 32'hC0FFEE11);
      // Second rank is refused once it is marked absent
      wr(CTRL | 21'h3C, 32'h00, 4'hF);
      wr(CTRL | 21'h2C, 32'h00, 4'hF);
      wr(21'h040000, 32'h1, 4'hF); chk(r, RESP_SLVERR);
      rd(21'h040000); chk({r, d}, {RESP_SLVERR, 32'h0});
      // Mid-run reset with the pixel clock stopped, so the raster starts at its origin
      wr(CTRL | 21'h3C, 32'h48, 4'hF);
      px_on <= 1'b0;
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CTRL | 21'h3C); chk(d, 0);
      // Tiny raster at 8 bpp: the word of line L is {L, ~L}, one word per line
      for (i = 0; i < 10; i++) wr(CTRL | 21'(VCFG[i][15:8]), 32'(VCFG[i][7:0]), 4'hF);
      px_on <= 1'b1;
      for (i = 0; i < 12; i++) begin
         n = 0;
         do begin @(posedge aclk); n++; end while (pix_valid !== 1'b1 && n < 500);
         chk(n < 500, 1);
         if (n >= 500) conclude();
         m = {16'(i / 4 % 2), ~16'(i / 4 % 2)};
         m = {11'h000, i % 4 == 3, 1'b0, i % 4 < 2, i / 4 % 2 == 0, 9'h000, m[i % 4 * 8 +: 8]};
         chk(vid, m);
      end
      conclude();
   end
endmodule : fbcm_bench

// *** sim/fbcm_vram.sv ***
// Behavioural video RAM and display word source facing the frame buffer controller
`timescale 1ns/1ps
module fbcm_vram (
   input wire logic aclk,              // Bus clock
   input wire logic fb_req,            // Access pulse
   input wire logic fb_we,             // Write
   input wire logic fb_rank,           // Rank select
   input wire logic [15:0] fb_addr,    // Word within rank
   input wire logic [3:0] fb_be,       // Byte enables
   input wire logic [31:0] fb_wdata,   // Write data
   output logic [31:0] fb_rdata,       // Read data
   input wire logic [16:0] disp_addr,  // Display word address
   output logic [31:0] disp_word       // Display word
);
   logic [31:0] mem [0:131071];  // Two ranks of 32-bit words, no parity bits
   logic [31:0] held = 32'h0;    // Last word read
   logic rd_d = 1'b0;            // A read was requested last cycle
   wire logic [16:0] idx = {fb_rank, fb_addr};  // Linear word index
   // Data stands in the request cycle and the two after; afterwards it turns over each cycle
   assign fb_rdata = (fb_req && !fb_we) ? mem[idx] : (rd_d ? held : ~held);
   // Pattern changes with every word so a stuck pointer shows
   assign disp_word = {disp_addr[15:0], ~disp_addr[15:0]};
   // Byte-lane merge on writes, capture on reads
   always @(posedge aclk) begin
      rd_d <= fb_req && !fb_we;
      held <= (fb_req && !fb_we) ? mem[idx] : ~held;
      for (int b = 0; b < 4; b++) begin
         if (fb_req && fb_we && fb_be[b]) mem[idx][b*8 +: 8] <= fb_wdata[b*8 +: 8];
      end
   end
endmodule : fbcm_vram
